/* File: bench/epki_pin_model.sv */
module epki_pin_model
  import epki_pkg::*;
(
  // clock
  input  wire logic        ref_clk,
  // pins towards the block
  output logic [N_EXT-1:0] ext_irq_pin_n,
  output logic [N_KEY-1:0] key_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // switches rest open, so pull-ups hold every pin high
  initial
  begin
    ext_irq_pin_n = '1;
    key_pin_n     = '1;
  end

  // an external line changes just after an edge
  task automatic set_ext(input int i, input logic v);
    @(posedge ref_clk);
    ext_irq_pin_n[i] <= v;
  endtask : set_ext

  // a key line changes just after an edge
  task automatic set_key(input int j, input logic v);
    @(posedge ref_clk);
    key_pin_n[j] <= v;
  endtask : set_key
endmodule : epki_pin_model

/* File: bench/test_ext_pin_and_key_irq.sv */
module test_ext_pin_and_key_irq
  import epki_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // design signals
  logic              ref_clk;
  logic              rstn;
  logic [N_EXT-1:0]  ext_irq_pin_n;
  logic [N_KEY-1:0]  key_pin_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr_en;
  logic              rd_en;
  logic [DATA_W-1:0] rd_data;
  logic [N_SRC-1:0]  irq_ack;
  logic [N_SRC-1:0]  request_flag;
  logic              irq;
  logic              wake_req;
  int                errors;
  int                tests_run;
  int                n;
  localparam logic [8:0] REGS [8] = '{OFS_EXT_EN0, OFS_EXT_EN1, OFS_EXT_FLT0,
    OFS_EXT_FLT1, OFS_KEY_EN0, OFS_KEY_EN1, OFS_EDGE_SEL, OFS_MASK};

  // block and the switches on its pins
  epki_ext_key_irq u_epki_ext_key_irq (.ref_clk(ref_clk), .rstn(rstn),
    .ext_irq_pin_n(ext_irq_pin_n), .key_pin_n(key_pin_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq_ack(irq_ack),
    .request_flag(request_flag), .irq(irq), .wake_req(wake_req));
  epki_pin_model u_epki_pin_model (.ref_clk(ref_clk), .ext_irq_pin_n(ext_irq_pin_n),
    .key_pin_n(key_pin_n));

  // 200 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic close_out();
    if (errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one-cycle write strobe
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : wr

  // one-cycle read strobe, data stands in the following cycle
  task automatic rd(input logic [8:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    chk(rd_data, exp);
  endtask : rd

  task automatic pause(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask : pause

  // cycles from a pin change until flag i is seen
  task automatic lat(input int i, output int c);
    c = 0;
    while (request_flag[i] !== 1'b1 && c < 120)
    begin
      @(posedge ref_clk);
      #1;
      c++;
    end
  endtask : lat

  task automatic ack(input int i);
    @(posedge ref_clk);
    irq_ack <= 6'h01 << i;
    @(posedge ref_clk);
    irq_ack <= 6'h00;
    #1;
    chk({2'h0, request_flag}, 8'h00);
  endtask : ack

  task automatic clr();
    wr(OFS_STATUS, 8'hff);
    pause(1);
  endtask : clr

  // only input i configured, pins idle so no edge results
  task automatic cfg_ext(input int i, input logic en, input logic both, input logic [1:0] c);
    wr(OFS_EXT_FLT0, (i < 4) ? {6'h00, c} << (2 * i) : 8'h00);
    wr(OFS_EXT_FLT1, (i == 4) ? {4'h0, c, 2'h0} : 8'h00);
    wr(OFS_EXT_EN1, (i == 4) ? {4'h0, both, en, 2'h0} : 8'h00);
    wr(OFS_EXT_EN0, (i < 4) ? {6'h00, both, en} << (2 * i) : 8'h00);
    clr();
  endtask : cfg_ext

  task automatic key_cfg(input int j, input logic use_b, input logic edge_select_bit);
    wr(OFS_KEY_EN0, (j < 4) ? {6'h00, edge_select_bit, use_b} << (2 * j) : 8'h00);
    wr(OFS_KEY_EN1, (j >= 4) ? {6'h00, edge_select_bit, use_b} << (2 * (j - 4)) : 8'h00);
  endtask : key_cfg

  // hang guard, far beyond the expected run of about 1200 cycles
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    errors++;
    close_out();
  end

  // main sequence
  initial
  begin
    errors = 0;
    tests_run = 0;
    rstn = 1'b0;
    addr = '0;
    wdata = '0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    irq_ack = '0;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    pause(4);
    // reset values, storage, unmapped address
    for (int k = 0; k < 8; k++)
    begin
      rd(REGS[k], REG_RESET);
      wr(REGS[k], (k < 6) ? 8'ha5 : 8'h05);
      rd(REGS[k], (k < 6) ? 8'ha5 : 8'h05);
      wr(REGS[k], 8'h00);
    end
    wr(9'h100, 8'hff);
    rd(9'h100, 8'h00);
    clr();
    // each input: one edge both ways, then both edges
    for (int i = 0; i < 5; i++)
    begin
      cfg_ext(i, 1'b1, 1'b0, FILT_NONE);
      wr(OFS_EDGE_SEL, 8'h00);
      wr(OFS_MASK, 8'h01 << i);
      u_epki_pin_model.set_ext(i, 1'b0);
      lat(i, n);
      chk(8'(n), 8'h05);
      chk({2'h0, request_flag}, 8'h01 << i);
      chk({7'h00, irq}, 8'h00);
      pause(1);
      chk({7'h00, irq}, 8'h01);
      ack(i);
      pause(1);
      chk({7'h00, irq}, 8'h00);
      u_epki_pin_model.set_ext(i, 1'b1);
      pause(12);
      chk({2'h0, request_flag}, 8'h00);
      wr(OFS_EDGE_SEL, 8'h01 << i);
      u_epki_pin_model.set_ext(i, 1'b0);
      pause(12);
      chk({2'h0, request_flag}, 8'h00);
      u_epki_pin_model.set_ext(i, 1'b1);
      lat(i, n);
      chk(8'(n), 8'h05);
      wr(OFS_EDGE_SEL, 8'h00);
      cfg_ext(i, 1'b1, 1'b1, FILT_NONE);
      u_epki_pin_model.set_ext(i, 1'b0);
      lat(i, n);
      chk(8'(n), 8'h05);
      ack(i);
      u_epki_pin_model.set_ext(i, 1'b1);
      lat(i, n);
      chk(8'(n), 8'h05);
      ack(i);
      // three samples at every clock, two-cycle glitch rejected
      cfg_ext(i, 1'b1, 1'b0, FILT_DIV1);
      u_epki_pin_model.set_ext(i, 1'b0);
      pause(1);
      u_epki_pin_model.set_ext(i, 1'b1);
      pause(12);
      chk({2'h0, request_flag}, 8'h00);
      u_epki_pin_model.set_ext(i, 1'b0);
      lat(i, n);
      chk(8'(n), 8'h07);
      u_epki_pin_model.set_ext(i, 1'b1);
      pause(12);
    end
    // slow sampling clocks stretch the wait
    cfg_ext(0, 1'b1, 1'b1, FILT_DIV8);
    u_epki_pin_model.set_ext(0, 1'b0);
    lat(0, n);
    chk(8'(n inside {[19:30]}), 8'h01);
    cfg_ext(0, 1'b1, 1'b1, FILT_DIV32);
    u_epki_pin_model.set_ext(0, 1'b1);
    lat(0, n);
    chk(8'(n inside {[67:102]}), 8'h01);
    // disabled input ignored; enabling on a low pin, masked then unmasked
    cfg_ext(0, 1'b0, 1'b0, FILT_NONE);
    wr(OFS_MASK, 8'h00);
    u_epki_pin_model.set_ext(0, 1'b0);
    pause(12);
    chk({2'h0, request_flag}, 8'h00);
    wr(OFS_EXT_EN0, 8'h01);
    pause(8);
    chk({2'h0, request_flag}, 8'h01);
    chk({7'h00, irq}, 8'h00);
    wr(OFS_MASK, 8'h01);
    pause(2);
    chk({7'h00, irq}, 8'h01);
    wr(OFS_STATUS, 8'h01);
    rd(OFS_STATUS, 8'h00);
    pause(1);
    chk({7'h00, irq}, 8'h00);
    u_epki_pin_model.set_ext(0, 1'b1);
    pause(8);
    // acknowledge lands in the cycle of a fresh request: the set must win
    u_epki_pin_model.set_ext(0, 1'b0);
    pause(3);
    @(posedge ref_clk);
    irq_ack <= 6'h01;
    @(posedge ref_clk);
    irq_ack <= 6'h00;
    #1;
    chk({2'h0, request_flag}, 8'h01);
    clr();
    wr(OFS_EXT_EN0, 8'h00);
    u_epki_pin_model.set_ext(0, 1'b1);
    // every key pin alone, falling polarity, with wake pulse
    wr(OFS_MASK, 8'h20);
    for (int j = 0; j < 8; j++)
    begin
      key_cfg(j, 1'b1, 1'b0);
      clr();
      u_epki_pin_model.set_key(j, 1'b0);
      lat(5, n);
      chk(8'(n), 8'h03);
      chk({7'h00, wake_req}, 8'h01);
      pause(1);
      chk({7'h00, wake_req}, 8'h00);
      ack(5);
      u_epki_pin_model.set_key(j, 1'b1);
      pause(8);
      chk({2'h0, request_flag}, 8'h00);
    end
    // rising polarity on a high pin requests at once
    key_cfg(0, 1'b1, 1'b1);
    pause(8);
    chk({2'h0, request_flag}, 8'h20);
    u_epki_pin_model.set_key(0, 1'b0);
    pause(6);
    clr();
    u_epki_pin_model.set_key(0, 1'b1);
    lat(5, n);
    chk(8'(n), 8'h03);
    // a held key blocks the others
    wr(OFS_KEY_EN0, 8'h05);
    clr();
    u_epki_pin_model.set_key(0, 1'b0);
    lat(5, n);
    chk(8'(n), 8'h03);
    ack(5);
    u_epki_pin_model.set_key(1, 1'b0);
    pause(8);
    chk({2'h0, request_flag}, 8'h00);
    u_epki_pin_model.set_key(0, 1'b1);
    u_epki_pin_model.set_key(1, 1'b1);
    pause(4);
    close_out();
  end
endmodule : test_ext_pin_and_key_irq

/* File: inc/epki_pkg.sv */
package epki_pkg;

  // bus geometry
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DATA_W = 8;

  // source counts
  localparam int unsigned N_EXT = 5;
  localparam int unsigned N_KEY = 8;
  localparam int unsigned N_SRC = 6;

  // register offsets
  localparam logic [8:0] OFS_EXT_EN0  = 9'h1fa;
  localparam logic [8:0] OFS_EXT_EN1  = 9'h1fb;
  localparam logic [8:0] OFS_EXT_FLT0 = 9'h1fc;
  localparam logic [8:0] OFS_EXT_FLT1 = 9'h1fd;
  localparam logic [8:0] OFS_KEY_EN0  = 9'h1fe;
  localparam logic [8:0] OFS_KEY_EN1  = 9'h1ff;
  localparam logic [8:0] OFS_EDGE_SEL = 9'h1f0;
  localparam logic [8:0] OFS_STATUS   = 9'h1f1;
  localparam logic [8:0] OFS_MASK     = 9'h1f2;

  // field positions
  localparam int unsigned EXT5_EN_BIT   = 2;
  localparam int unsigned EXT5_MODE_BIT = 3;
  localparam int unsigned EXT5_FLT_LO   = 2;
  localparam int unsigned KEY_SRC_BIT   = 5;

  // reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic       PIN_IDLE  = 1'b1;

  // filter select codes
  localparam logic [1:0] FILT_NONE  = 2'h0;
  localparam logic [1:0] FILT_DIV1  = 2'h1;
  localparam logic [1:0] FILT_DIV8  = 2'h2;
  localparam logic [1:0] FILT_DIV32 = 2'h3;

  // sampling prescaler and filter counts
  localparam int unsigned PRE_W      = 5;
  localparam logic [2:0]  DIV8_LAST  = 3'h7;
  localparam logic [4:0]  DIV32_LAST = 5'h1f;
  localparam logic [1:0]  MATCH_NEED = 2'h3;

  // per external input settings
  typedef struct packed {
    logic       enable;
    logic       both;
    logic       edge_sel;
    logic [1:0] fcode;
  } epki_chan_cfg_t;

endpackage : epki_pkg

/* File: rtl/epki_ext_chan.sv */
module epki_ext_chan
  import epki_pkg::*;
(
  // clock and reset
  input  wire logic     ref_clk,
  input  wire logic     rstn,
  // synchronised pin and settings
  input  wire logic     pin_sync,
  input  epki_chan_cfg_t cfg,
  input  wire logic [2:0] smp_stb,
  // one-cycle request
  output logic          req
);

  logic       smp_q;
  logic [1:0] cnt_q;
  logic       filt_q;
  logic       prev_q;
  logic       req_q;

  // sampling clock pick and level seen by the detector
  wire        filter_on = (cfg.fcode != FILT_NONE);
  wire        sel_stb   = (cfg.fcode == FILT_DIV1) ? smp_stb[0] :
                          (cfg.fcode == FILT_DIV8) ? smp_stb[1] : smp_stb[2];
  wire        gated     = cfg.enable ? pin_sync : PIN_IDLE;
  wire        same      = (gated == smp_q);
  wire [1:0]  cnt_d     = !same ? 2'h1 :
                          (cnt_q == MATCH_NEED) ? cnt_q : cnt_q + 2'h1;

  // edge decode on the filtered level
  wire        fall = prev_q & ~filt_q;
  wire        rise = ~prev_q & filt_q;
  wire        hit  = cfg.both ? (fall | rise) : (cfg.edge_sel ? rise : fall);
  wire        req_d = cfg.enable & hit;

  // three-sample filter, bypassed when off
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      smp_q  <= PIN_IDLE;
      cnt_q  <= MATCH_NEED;
      filt_q <= PIN_IDLE;
    end
    else if (!filter_on)
    begin
      smp_q  <= gated;
      cnt_q  <= MATCH_NEED;
      filt_q <= gated;
    end
    else if (sel_stb)
    begin
      smp_q <= gated;
      cnt_q <= cnt_d;
      if (cnt_d == MATCH_NEED)
        filt_q <= gated;
    end
  end

  // edge history and request pulse
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prev_q <= PIN_IDLE;
      req_q  <= 1'b0;
    end
    else
    begin
      prev_q <= filt_q;
      req_q  <= req_d;
    end
  end

  assign req = req_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  property p_disabled_quiet;
    !cfg.enable |=> !req;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("disabled input raised a request");

  property p_both_edges;
    cfg.enable && cfg.both && (filt_q != prev_q) |=> req;
  endproperty
  a_both_edges: assert property (p_both_edges)
    else $error("both-edge mode missed an edge");

  property p_one_edge_pol;
    cfg.enable && !cfg.both && (cfg.edge_sel ? fall : rise) |=> !req;
  endproperty
  a_one_edge_pol: assert property (p_one_edge_pol)
    else $error("one-edge mode took the wrong edge");

  property p_three_match;
    filter_on && $past(filter_on) && (filt_q != $past(filt_q)) |-> cnt_q == MATCH_NEED;
  endproperty
  a_three_match: assert property (p_three_match)
    else $error("filter changed level before three matching samples");

  c_filtered_req: cover property (filter_on && req);

endmodule : epki_ext_chan

/* File: rtl/epki_ext_key_irq.sv */
// How it works
// - an external input raises requests only while its enable bit is set.
// - each external input has an edge-mode bit beside its enable, 1 means both edges.
// - in one-edge mode the control edge-select bit picks falling or rising.
// - rewriting the first enable register may set a spurious request flag.
// - input five takes enable from bit 2 and edge mode from bit 3.
// - two-bit filter code: none, every clock, divide by 8, divide by 32.
// - input five takes its filter code from bits 2 and 3 of filter register 1.
// - with filtering, three agreeing samples are needed before the flag sets.
// - any qualifying edge on the eight key pins gives one key request.
// - a key request also acts as a wake-up event out of wait or stop.
// - each key pin has a use bit and a polarity bit, 1 meaning rising.
// - while an enabled key pin sits at its active level, other pins are ignored.
// - rewriting a key enable register may set a spurious key request flag.
// - flags set on a request and clear when the processor acknowledges.
//
// Local design decision: the address-and-strobe port.
module epki_ext_key_irq
  import epki_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  // external pins, active low idle high
  input  wire logic [N_EXT-1:0]  ext_irq_pin_n,
  input  wire logic [N_KEY-1:0]  key_pin_n,
  // register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic [DATA_W-1:0]      rd_data,
  // processor acknowledge, one bit per source
  input  wire logic [N_SRC-1:0]  irq_ack,
  // interrupt and wake outputs
  output logic [N_SRC-1:0]       request_flag,
  output logic                   irq,
  output logic                   wake_req
);

  localparam int unsigned N_PIN = N_EXT + N_KEY;

  logic [N_PIN-1:0]  sync1_q;
  logic [N_PIN-1:0]  sync2_q;
  logic [7:0]        ext_en0_q;
  logic [7:0]        ext_en1_q;
  logic [7:0]        ext_flt0_q;
  logic [7:0]        ext_flt1_q;
  logic [7:0]        key_en0_q;
  logic [7:0]        key_en1_q;
  logic [N_EXT-1:0]  edge_sel_q;
  logic [N_SRC-1:0]  stat_q;
  logic [N_SRC-1:0]  stat_d;
  logic [N_SRC-1:0]  mask_q;
  logic [DATA_W-1:0] rd_data_q;
  logic              irq_q;
  logic              wake_q;
  logic              key_any_q;
  logic [PRE_W-1:0]  pre_q;

  epki_chan_cfg_t    ext_cfg [N_EXT];
  logic [N_EXT-1:0]  ext_req;
  logic [N_KEY-1:0]  key_act;

  // two-stage synchroniser for all pins
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_q <= '1;
      sync2_q <= '1;
    end
    else
    begin
      sync1_q <= {key_pin_n, ext_irq_pin_n};
      sync2_q <= sync1_q;
    end
  end

  wire [N_EXT-1:0] ext_sync = sync2_q[N_EXT-1:0];
  wire [N_KEY-1:0] key_sync = sync2_q[N_PIN-1:N_EXT];

  // sampling clock prescaler, free running
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      pre_q <= '0;
    else
      pre_q <= pre_q + 5'h01;
  end

  wire [2:0] smp_stb = {pre_q == DIV32_LAST, pre_q[2:0] == DIV8_LAST, 1'b1};

  // register write decode
  wire wr_en0   = wr_en && (addr == OFS_EXT_EN0);
  wire wr_en1   = wr_en && (addr == OFS_EXT_EN1);
  wire wr_flt0  = wr_en && (addr == OFS_EXT_FLT0);
  wire wr_flt1  = wr_en && (addr == OFS_EXT_FLT1);
  wire wr_key0  = wr_en && (addr == OFS_KEY_EN0);
  wire wr_key1  = wr_en && (addr == OFS_KEY_EN1);
  wire wr_esel  = wr_en && (addr == OFS_EDGE_SEL);
  wire wr_stat  = wr_en && (addr == OFS_STATUS);
  wire wr_mask  = wr_en && (addr == OFS_MASK);

  // settings registers
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ext_en0_q  <= REG_RESET;
      ext_en1_q  <= REG_RESET;
      ext_flt0_q <= REG_RESET;
      ext_flt1_q <= REG_RESET;
      key_en0_q  <= REG_RESET;
      key_en1_q  <= REG_RESET;
    end
    else
    begin
      if (wr_en0)
        ext_en0_q <= wdata;
      if (wr_en1)
        ext_en1_q <= wdata;
      if (wr_flt0)
        ext_flt0_q <= wdata;
      if (wr_flt1)
        ext_flt1_q <= wdata;
      if (wr_key0)
        key_en0_q <= wdata;
      if (wr_key1)
        key_en1_q <= wdata;
    end
  end

  // edge-select and mask registers
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      edge_sel_q <= '0;
      mask_q     <= '0;
    end
    else
    begin
      if (wr_esel)
        edge_sel_q <= wdata[N_EXT-1:0];
      if (wr_mask)
        mask_q <= wdata[N_SRC-1:0];
    end
  end

  // inputs 0 to 3 take their bits in pairs
  genvar gi;
  generate
    for (gi = 0; gi < N_EXT - 1; gi++)
    begin : g_ext_cfg
      assign ext_cfg[gi] = {ext_en0_q[2*gi], ext_en0_q[2*gi+1], edge_sel_q[gi],
                            ext_flt0_q[2*gi+1 -: 2]};
    end
  endgenerate

  // input five sits in the second pair of the second registers
  assign ext_cfg[N_EXT-1] = {ext_en1_q[EXT5_EN_BIT], ext_en1_q[EXT5_MODE_BIT],
                             edge_sel_q[N_EXT-1],
                             ext_flt1_q[EXT5_FLT_LO+1 -: 2]};

  // one filter and edge detector per external input
  generate
    for (gi = 0; gi < N_EXT; gi++)
    begin : g_ext_chan
      epki_ext_chan u_chan (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .pin_sync (ext_sync[gi]),
        .cfg      (ext_cfg[gi]),
        .smp_stb  (smp_stb),
        .req      (ext_req[gi])
      );
    end
  endgenerate

  // key pin active levels; a disabled pin never counts
  wire [2*N_KEY-1:0] key_cfg = {key_en1_q, key_en0_q};

  generate
    for (gi = 0; gi < N_KEY; gi++)
    begin : g_key
      assign key_act[gi] = key_cfg[2*gi] &
                           (key_cfg[2*gi+1] ? key_sync[gi] : ~key_sync[gi]);
    end
  endgenerate

  // any active pin holds off the others; enabling an active pin fires
  wire key_any = |key_act;
  wire key_req = key_any & ~key_any_q;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      key_any_q <= 1'b0;
      wake_q    <= 1'b0;
    end
    else
    begin
      key_any_q <= key_any;
      wake_q    <= key_req;
    end
  end

  // request flags: set beats any clear in the same cycle
  wire [N_SRC-1:0] src_req = {key_req, ext_req};
  wire [N_SRC-1:0] clr_vec = (wr_stat ? wdata[N_SRC-1:0] : '0) | irq_ack;

  assign stat_d = (stat_q & ~clr_vec) | src_req;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stat_q <= '0;
      irq_q  <= 1'b0;
    end
    else
    begin
      stat_q <= stat_d;
      irq_q  <= |(stat_q & mask_q);
    end
  end

  // read selection, unmapped reads as zero
  wire [DATA_W-1:0] rd_mux =
    (addr == OFS_EXT_EN0)  ? ext_en0_q  :
    (addr == OFS_EXT_EN1)  ? ext_en1_q  :
    (addr == OFS_EXT_FLT0) ? ext_flt0_q :
    (addr == OFS_EXT_FLT1) ? ext_flt1_q :
    (addr == OFS_KEY_EN0)  ? key_en0_q  :
    (addr == OFS_KEY_EN1)  ? key_en1_q  :
    (addr == OFS_EDGE_SEL) ? {3'h0, edge_sel_q} :
    (addr == OFS_STATUS)   ? {2'h0, stat_q} :
    (addr == OFS_MASK)     ? {2'h0, mask_q} : 8'h00;

  wire rd_hit = (addr == OFS_EDGE_SEL) || (addr == OFS_STATUS) || (addr == OFS_MASK) ||
                ((addr >= OFS_EXT_EN0) && (addr <= OFS_KEY_EN1));

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      rd_data_q <= '0;
    else if (rd_en)
      rd_data_q <= rd_mux;
    else
      rd_data_q <= '0;
  end

  assign rd_data      = rd_data_q;
  assign request_flag = stat_q;
  assign irq          = irq_q;
  assign wake_req     = wake_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  property p_sync_delay;
    $past(rstn, 2) |-> sync2_q == $past({key_pin_n, ext_irq_pin_n}, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("pin did not pass exactly two flip-flops");

  property p_ext5_map;
    wr_en1 |=> ext_cfg[N_EXT-1].enable == $past(wdata[2]) &&
               ext_cfg[N_EXT-1].both == $past(wdata[3]);
  endproperty
  a_ext5_map: assert property (p_ext5_map)
    else $error("input five enable or mode taken from wrong bits");

  property p_flt0_map;
    wr_flt0 |=> ext_cfg[1].fcode == $past(wdata[3:2]);
  endproperty
  a_flt0_map: assert property (p_flt0_map)
    else $error("input one filter code taken from wrong bits");

  property p_flt1_map;
    wr_flt1 |=> ext_cfg[N_EXT-1].fcode == $past(wdata[3:2]);
  endproperty
  a_flt1_map: assert property (p_flt1_map)
    else $error("input five filter code taken from wrong bits");

  property p_key_flag;
    key_req |=> stat_q[KEY_SRC_BIT] ##1 !wake_req || stat_q[KEY_SRC_BIT];
  endproperty
  a_key_flag: assert property (p_key_flag)
    else $error("key request did not set its flag");

  property p_key_hold;
    $past(key_any) && key_any |-> !key_req ##1 !wake_req;
  endproperty
  a_key_hold: assert property (p_key_hold)
    else $error("key request while another pin held active");

  property p_wake;
    key_req |=> wake_req ##1 !wake_req;
  endproperty
  a_wake: assert property (p_wake)
    else $error("key request gave no single wake pulse");

  property p_set_wins;
    ext_req[0] && irq_ack[0] |=> request_flag[0];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("request lost against a same-cycle acknowledge");

  property p_ack_clear;
    irq_ack[0] && !ext_req[0] |=> !request_flag[0];
  endproperty
  a_ack_clear: assert property (p_ack_clear)
    else $error("acknowledge did not clear the flag");

  property p_unmapped_zero;
    rd_en && !rd_hit |=> rd_data == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read returned nonzero data");

  property p_irq_follow;
    ##1 irq == $past(|(stat_q & mask_q));
  endproperty
  a_irq_follow: assert property (p_irq_follow)
    else $error("interrupt output does not follow unmasked flags");

  c_ext_req: cover property (ext_req[0] ##[1:4] irq);
  c_key_req: cover property (key_req ##1 wake_req);
  c_spurious: cover property (wr_key0 ##1 key_req);
  c_both_req: cover property (ext_cfg[1].both && ext_req[1]);

endmodule : epki_ext_key_irq
